// ===== hdl/switch_monitor_pkg.sv
package switch_monitor_pkg;
    localparam int FRAME_BITS = 32;
    localparam int DATA_BITS = 30;
    localparam int CHANNELS = 24;
    localparam int SEL_BITS = 2;
    // register select codes
    localparam logic [1:0] SEL_WETLO = 2'h0;
    localparam logic [1:0] SEL_WETHI = 2'h1;
    localparam logic [1:0] SEL_TYPE = 2'h2;
    localparam logic [1:0] SEL_NOP = 2'h3;
    // data field positions (data bit index)
    localparam int CH_LSB = 1;
    localparam int CH_MSB = 24;
    localparam int CODE_LSB = 25;
    localparam int PACT_MSB = 27;
    localparam int PPER_MSB = 28;
    localparam int LQ_BIT = 28;
    localparam int TYPE_MSB = 29;
    // reset values
    localparam logic [3:0] POLL_PERIOD_RST = 4'h0;
    localparam logic [2:0] POLL_ACTIVE_RST = 3'h3;
    localparam logic LQ_RST = 1'b0;
    localparam logic [4:0] INPUT_TYPE_RST = 5'h00;
    localparam logic [23:0] CH_RST = 24'h000000;
    // arbitrary neutral identity value
    localparam logic DEVICE_TYPE_VAL = 1'b0;
    // poll period / active time bases
    localparam real POLL_PERIOD_BASE_MS = 4.096;
    localparam real POLL_ACTIVE_BASE_US = 64.0;
endpackage : switch_monitor_pkg

// ===== hdl/switch_monitor_config_regs.sv
`timescale 1ns/1ps
module switch_monitor_config_regs
    import switch_monitor_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spiClk,
    input wire logic chipSelectN,
    input wire logic spiDataIn,
    output logic spiDataOut,
    input wire logic [switch_monitor_pkg::CHANNELS-1:0] switchClosed,
    input wire logic overTempEvent,
    output logic [switch_monitor_pkg::CHANNELS-1:0] wettingCode0,
    output logic [switch_monitor_pkg::CHANNELS-1:0] wettingCode1,
    output logic [switch_monitor_pkg::CHANNELS-1:0] channelIrqEnable,
    output logic [4:0] inputTypeSelect,
    output logic [3:0] pollPeriodCode,
    output logic [2:0] pollActiveCode,
    output logic lowQuiescentSelect,
    output logic continuousMode,
    output logic [switch_monitor_pkg::CHANNELS-1:0] channelMonitored
);
    import switch_monitor_pkg::*;

    // derived sizes
    localparam int CNT_BITS = $clog2(FRAME_BITS);
    localparam int STATUS_PAD = FRAME_BITS - CHANNELS - 3;

    // refuse sizes that the logic cannot serve
    if ((1 << CNT_BITS) != FRAME_BITS) begin : g_bad_count
        $error("frame length must be a power of two");
    end
    if (DATA_BITS + SEL_BITS != FRAME_BITS) begin : g_bad_split
        $error("data and select bits must fill the frame");
    end
    if (CH_MSB - CH_LSB + 1 != CHANNELS) begin : g_bad_chan
        $error("channel field must hold one bit per channel");
    end
    if (STATUS_PAD < 1) begin : g_bad_status
        $error("status word too narrow for the channels");
    end

    // period code zero means continuous sensing
    function automatic logic isContinuous(input logic [3:0] code);
        return code == POLL_PERIOD_RST;
    endfunction : isContinuous

    // every channel when continuous or low-quiescent set, else enabled ones
    function automatic logic [CHANNELS-1:0] monitorSet(
        input logic contMode,
        input logic lowQuiescent,
        input logic [CHANNELS-1:0] irqEnable
    );
        return (contMode || lowQuiescent) ? {CHANNELS{1'b1}} : irqEnable;
    endfunction : monitorSet

    // pin synchronisers, two stages before any logic reads a pin
    logic [1:0] clkSync;
    logic [1:0] csSync;
    logic [1:0] dinSync;
    logic [1:0] otSync;
    logic [CHANNELS-1:0] swMeta;
    logic [CHANNELS-1:0] swSync;
    logic clkPrev;
    logic csPrev;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clkSync <= '0;
            csSync <= '1; // idle high, no false frame start
            dinSync <= '0;
            otSync <= '0;
            swMeta <= CH_RST;
            swSync <= CH_RST;
            clkPrev <= 1'b0;
            csPrev <= 1'b1;
        end else begin
            clkSync <= {clkSync[0], spiClk};
            csSync <= {csSync[0], chipSelectN};
            dinSync <= {dinSync[0], spiDataIn};
            otSync <= {otSync[0], overTempEvent};
            swMeta <= switchClosed;
            swSync <= swMeta;
            clkPrev <= clkSync[1];
            csPrev <= csSync[1];
        end
    end

    // edge detection on synchronised pins
    wire sclkRise = clkSync[1] & ~clkPrev;
    wire sclkFall = ~clkSync[1] & clkPrev;
    wire csFall = ~csSync[1] & csPrev;
    wire csRise = csSync[1] & ~csPrev;
    wire csActive = ~csSync[1];

    // frame state
    logic [FRAME_BITS-1:0] shiftIn;
    logic [FRAME_BITS-1:0] shiftOut;
    logic [CNT_BITS-1:0] bitCount;
    logic anyBits;
    logic overTemp;
    logic powerOnFlag;

    // status word: bit31 type, 30 power-on, 29 overtemp, 23..0 switches
    wire [FRAME_BITS-1:0] statusWord = {DEVICE_TYPE_VAL, powerOnFlag,
        overTemp, {STATUS_PAD{1'b0}}, swSync};

    // received frame fields, data bits sit above the select bits
    wire [SEL_BITS-1:0] frameSel = shiftIn[SEL_BITS-1:0];
    wire [DATA_BITS-1:0] frameData = shiftIn[FRAME_BITS-1:SEL_BITS];
    wire [CHANNELS-1:0] chField = frameData[CH_MSB:CH_LSB];
    wire frameAligned = (bitCount == '0) && anyBits;
    wire latchFrame = csRise && frameAligned && (frameSel != SEL_NOP);

    // register write strobes, one per select code other than SEL_NOP
    wire wrLow = latchFrame && (frameSel == SEL_WETLO);
    wire wrHigh = latchFrame && (frameSel == SEL_WETHI);
    wire wrType = latchFrame && (frameSel == SEL_TYPE);

    // serial shift and bit counter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shiftIn <= '0;
            bitCount <= '0;
            anyBits <= 1'b0;
        end else if (csFall) begin
            bitCount <= '0;
            anyBits <= 1'b0;
        end else if (csActive && sclkRise) begin
            shiftIn <= {shiftIn[FRAME_BITS-2:0], dinSync[1]};
            bitCount <= bitCount + CNT_BITS'(1);
            anyBits <= 1'b1;
        end
    end

    // status output shift, msb first, refreshed at frame start
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shiftOut <= '0;
        end else if (csFall) begin
            shiftOut <= statusWord;
        end else if (csActive && sclkFall) begin
            shiftOut <= {shiftOut[FRAME_BITS-2:0], shiftIn[FRAME_BITS-1]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            spiDataOut <= 1'b0;
        end else begin
            spiDataOut <= shiftOut[FRAME_BITS-1];
        end
    end

    // status flags, event wins over clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            overTemp <= 1'b0;
            powerOnFlag <= 1'b0;
        end else begin
            if (otSync[1]) begin
                overTemp <= 1'b1;
            end else if (csRise) begin
                overTemp <= 1'b0;
            end
            if (csRise) begin
                powerOnFlag <= 1'b1;
            end
        end
    end

    // first command register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wettingCode0 <= CH_RST;
            pollActiveCode <= POLL_ACTIVE_RST;
            lowQuiescentSelect <= LQ_RST;
        end else if (wrLow) begin
            wettingCode0 <= chField;
            pollActiveCode <= frameData[PACT_MSB:CODE_LSB];
            lowQuiescentSelect <= frameData[LQ_BIT];
        end
    end

    // second command register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wettingCode1 <= CH_RST;
            pollPeriodCode <= POLL_PERIOD_RST;
        end else if (wrHigh) begin
            wettingCode1 <= chField;
            pollPeriodCode <= frameData[PPER_MSB:CODE_LSB];
        end
    end

    // third command register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            channelIrqEnable <= CH_RST;
            inputTypeSelect <= INPUT_TYPE_RST;
        end else if (wrType) begin
            channelIrqEnable <= chField;
            inputTypeSelect <= frameData[TYPE_MSB:CODE_LSB];
        end
    end

    // next mode and monitored set, from the values about to be latched
    wire [3:0] next_pollPeriodCode = wrHigh ?
        frameData[PPER_MSB:CODE_LSB] : pollPeriodCode;
    wire next_lowQuiescentSelect = wrLow ? frameData[LQ_BIT] :
        lowQuiescentSelect;
    wire [CHANNELS-1:0] next_channelIrqEnable = wrType ? chField :
        channelIrqEnable;
    wire next_continuousMode = isContinuous(next_pollPeriodCode);
    wire [CHANNELS-1:0] next_channelMonitored = monitorSet(
        next_continuousMode, next_lowQuiescentSelect,
        next_channelIrqEnable);

    // mode outputs registered in step with the command registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            continuousMode <= isContinuous(POLL_PERIOD_RST);
            channelMonitored <= monitorSet(isContinuous(POLL_PERIOD_RST),
                LQ_RST, CH_RST);
        end else begin
            continuousMode <= next_continuousMode;
            channelMonitored <= next_channelMonitored;
        end
    end
endmodule : switch_monitor_config_regs

// ===== verif/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clk,
    input wire logic miso,
    output logic sck,
    output logic csN,
    output logic mosi
);
    logic [31:0] rd;
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        mosi = 1'b0;
    end
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    // mode 0 frame, msb first, select bits last
    task automatic xfer(input logic [31:0] w, input int n);
        @(negedge clk) csN = 1'b0;
        tick(8);
        for (int i = 31; i > 31 - n; i--) begin
            mosi = w[i];
            tick(4);
            sck = 1'b1;
            rd = {rd[30:0], miso};
            tick(4);
            sck = 1'b0;
        end
        mosi = ~mosi; // released line must not hold
        tick(4);
        csN = 1'b1;
        tick(12);
    endtask : xfer
endmodule : spi_host_model

// ===== verif/switch_monitor_config_regs_assertions.sv
`timescale 1ns/1ps
module switch_monitor_config_regs_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic chipSelectN,
    input wire logic [23:0] wettingCode0,
    input wire logic [23:0] wettingCode1,
    input wire logic [23:0] channelIrqEnable,
    input wire logic [4:0] inputTypeSelect,
    input wire logic [3:0] pollPeriodCode,
    input wire logic [2:0] pollActiveCode,
    input wire logic lowQuiescentSelect,
    input wire logic continuousMode,
    input wire logic [23:0] channelMonitored
);
    wire logic [84:0] cfg = {wettingCode0, wettingCode1, channelIrqEnable,
        inputTypeSelect, pollPeriodCode, pollActiveCode, lowQuiescentSelect};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // mode and monitored channels
    property p_cont; continuousMode == (pollPeriodCode == 4'h0); endproperty
    a_cont: assert property (p_cont) else $error("continuous flag");
    property p_all; continuousMode || lowQuiescentSelect |-> &channelMonitored;
    endproperty
    a_all: assert property (p_all) else $error("monitor all");
    property p_irq; !continuousMode && !lowQuiescentSelect
        |-> channelMonitored == channelIrqEnable; endproperty
    a_irq: assert property (p_irq) else $error("monitor enabled");
    // latching only after a frame ends
    property p_busy; !chipSelectN [*6] |=> $stable(cfg); endproperty
    a_busy: assert property (p_busy) else $error("change in frame");
    property p_idle; chipSelectN [*8] |=> $stable(cfg); endproperty
    a_idle: assert property (p_idle) else $error("change when idle");
    property p_upd; $changed(cfg) |-> $past(chipSelectN, 2); endproperty
    a_upd: assert property (p_upd) else $error("late latch");
    // reset values
    property p_rsta; $fell(rst) |-> pollActiveCode == 3'h3; endproperty
    a_rsta: assert property (p_rsta) else $error("active reset");
    property p_rstb; $fell(rst) |-> cfg[84:4] == '0 && cfg[0] == 1'b0;
    endproperty
    a_rstb: assert property (p_rstb) else $error("cfg reset");
    c_upd: cover property ($changed(cfg));
    c_irq: cover property (!continuousMode && !lowQuiescentSelect);
    c_frame: cover property ($rose(chipSelectN));
endmodule : switch_monitor_config_regs_chk
bind switch_monitor_config_regs switch_monitor_config_regs_chk u_chk (
    .clk_sys(clk_sys),
    .rst(rst),
    .chipSelectN(chipSelectN),
    .wettingCode0(wettingCode0),
    .wettingCode1(wettingCode1),
    .channelIrqEnable(channelIrqEnable),
    .inputTypeSelect(inputTypeSelect),
    .pollPeriodCode(pollPeriodCode),
    .pollActiveCode(pollActiveCode),
    .lowQuiescentSelect(lowQuiescentSelect),
    .continuousMode(continuousMode),
    .channelMonitored(channelMonitored)
);

// ===== verif/switch_monitor_config_regs_tb.sv
`timescale 1ns/1ps
module switch_monitor_config_regs_tb;
    import switch_monitor_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic overTempEvent = 1'b0;
    logic [23:0] switchClosed = 24'h5a0f3c;
    logic spiClk, chipSelectN, spiDataIn, spiDataOut;
    logic [23:0] wettingCode0, wettingCode1;
    logic [23:0] channelIrqEnable, channelMonitored;
    logic [4:0] inputTypeSelect;
    logic [3:0] pollPeriodCode;
    logic [2:0] pollActiveCode;
    logic lowQuiescentSelect, continuousMode;
    int n_fail = 0;
    int total_checks = 0;
    always #20 clk_sys = ~clk_sys;
    switch_monitor_config_regs u_dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .spiClk(spiClk),
        .chipSelectN(chipSelectN),
        .spiDataIn(spiDataIn),
        .spiDataOut(spiDataOut),
        .switchClosed(switchClosed),
        .overTempEvent(overTempEvent),
        .wettingCode0(wettingCode0),
        .wettingCode1(wettingCode1),
        .channelIrqEnable(channelIrqEnable),
        .inputTypeSelect(inputTypeSelect),
        .pollPeriodCode(pollPeriodCode),
        .pollActiveCode(pollActiveCode),
        .lowQuiescentSelect(lowQuiescentSelect),
        .continuousMode(continuousMode),
        .channelMonitored(channelMonitored)
    );
    spi_host_model u_host (.clk(clk_sys), .miso(spiDataOut), .sck(spiClk),
        .csN(chipSelectN), .mosi(spiDataIn));
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [29:0] d, input logic [1:0] s);
        u_host.xfer({d, s}, 32);
    endtask : wr
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    initial begin
        #1000000;
        n_fail++;
        final_report();
    end
    initial begin
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("active", pollActiveCode, 32'h3);
        chk("irq", channelIrqEnable, 32'h0);
        chk("type", inputTypeSelect, 32'h0);
        chk("mon", channelMonitored, 32'hffffff);
        chk("wet0rst", wettingCode0, 32'h0);
        chk("wet1rst", wettingCode1, 32'h0);
        chk("perrst", {continuousMode, pollPeriodCode}, 32'h10);
        chk("lqrst", lowQuiescentSelect, 32'h0);
        $display("test reset done");
        wr({2'h3, 3'h6, 24'ha5c3f0, 1'b1}, SEL_WETLO);
        chk("stat", u_host.rd[31:30], {DEVICE_TYPE_VAL, 1'b0});
        chk("sw", u_host.rd[23:0], switchClosed);
        chk("wet0", wettingCode0, 32'ha5c3f0);
        chk("pact", {lowQuiescentSelect, pollActiveCode}, 32'he);
        wr({1'b1, 4'h9, 24'h0f0f0f, 1'b1}, SEL_WETHI);
        chk("wet1", wettingCode1, 32'h0f0f0f);
        chk("per", {continuousMode, pollPeriodCode}, 32'h9);
        wr({5'h15, 24'h123456, 1'b1}, SEL_TYPE);
        chk("type", {inputTypeSelect, channelIrqEnable}, 32'h15123456);
        chk("mon", channelMonitored, 32'hffffff);
        wr({2'h0, 3'h6, 24'ha5c3f0, 1'b1}, SEL_WETLO);
        chk("mon", channelMonitored, 32'h123456);
        $display("test write done");
        @(negedge clk_sys) overTempEvent = 1'b1;
        @(negedge clk_sys) overTempEvent = 1'b0;
        wr('1, SEL_NOP);
        chk("ot", u_host.rd[31:29], {DEVICE_TYPE_VAL, 2'h3});
        chk("nop", {lowQuiescentSelect, pollPeriodCode}, 32'h9);
        chk("nopwet", wettingCode0, 32'ha5c3f0);
        u_host.xfer({30'h0, SEL_WETLO}, 31);
        chk("otclr", u_host.rd[28], 32'h0);
        chk("short", wettingCode0, 32'ha5c3f0);
        $display("test status done");
        @(negedge clk_sys) rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("rerst", {continuousMode, pollPeriodCode}, 32'h10);
        chk("rerstirq", channelIrqEnable, 32'h0);
        chk("rerstwet", wettingCode0, 32'h0);
        wr('1, SEL_NOP);
        chk("rerstpor", u_host.rd[31:29], {DEVICE_TYPE_VAL, 2'h0});
        $display("test second reset done");
        final_report();
    end
endmodule : switch_monitor_config_regs_tb
